// ===== include/smi_pkg.sv
// shared constants and carriers of the management interrupt enable block
`default_nettype none
package smi_pkg;

    localparam int NREG = 6;

    // status bank offsets, slot 0 first
    localparam logic [NREG-1:0][7:0] STS_OFF =
        {8'h15, 8'h14, 8'h13, 8'h12, 8'h11, 8'h10};
    // enable bank offsets, slot 0 first
    localparam logic [NREG-1:0][7:0] EN_OFF =
        {8'h1b, 8'h1a, 8'h19, 8'h18, 8'h17, 8'h16};

    // writable enable bits, reserved ones stay zero
    localparam logic [NREG-1:0][7:0] EN_WMASK =
        {8'hff, 8'hff, 8'hff, 8'h7f, 8'hdf, 8'h9e};
    // enable bits that gate a source into the merge
    localparam logic [NREG-1:0][7:0] EN_GATE =
        {8'hff, 8'hff, 8'hff, 8'h7f, 8'h1f, 8'h9e};
    localparam logic [7:0] EN_RST = 8'h00;

    // status bits that follow their source level
    localparam logic [NREG-1:0][7:0] STS_LEVEL =
        {8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h9e};
    // status bits cleared by writing a one
    localparam logic [NREG-1:0][7:0] STS_W1C =
        {8'hff, 8'hff, 8'hff, 8'hff, 8'h1c, 8'h00};
    localparam logic [NREG-1:0][7:0] STS_RST =
        {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02};

    // slot of the second enable register and its routing bits
    localparam int SLOT_B = 1;
    localparam int ROUTE_SIRQ_BIT = 6;
    localparam int ROUTE_PIN_BIT = 7;
    // sticky smbus bit of the second status register
    localparam int SMB_BIT = 2;

    localparam logic [7:0] RD_IDLE = 8'h00;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_s;

    // interrupt and event sources
    typedef struct packed {
        logic [7:0] periph;  // level, bit layout of the first bank
        logic       mouse;   // level
        logic       kbd;     // level
        logic       smb;     // event pulse
        logic       ring;    // event pulse
        logic       kbc_pin; // event pulse
        logic [7:0] gp_a;    // event pulses, third bank
        logic [7:0] gp_b;    // event pulses, bit 5 is input_a
        logic [7:0] gp_c;    // event pulses, fifth bank
        logic [7:0] gp_d;    // event pulses, sixth bank
    } smi_src_s;

endpackage
`default_nettype wire

// ===== rtl/smi_enable_aggregator.sv
// enable masks merging interrupt and event sources into one management interrupt
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - first enable gates peripheral interrupts, bits 1-4,7
// - second enable bits 0-4 gate peripheral events
// - bit 6 routes merged interrupt to serial stream
// - bit 7 drives pin, else pin floats
// - third enable gates seven general pins
// - fourth enable gates pins and tachometer input
// - fifth enable gates pins fifty to fifty-seven
// - sixth enable gates pins ten to seventeen
// - sticky event status clears on written one
// - peripheral status follows source, no write clear
module smi_enable_aggregator (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire smi_pkg::reg_req_s req,
    output logic [7:0]             rdata,
    input  wire smi_pkg::smi_src_s src,
    output logic                   merged_mgmt_irq_n,
    output logic                   mgmt_irq_pin_n,
    output logic                   mgmt_irq_pin_oe_n,
    output logic                   serial_irq_smi
);
    import smi_pkg::*;

    logic [NREG-1:0][7:0] en_q;
    logic [NREG-1:0][7:0] sts_q;
    logic [NREG-1:0][7:0] set_d;
    logic [NREG-1:0][7:0] hit_d;
    logic [7:0]           rdata_q;
    logic [7:0]           rdata_d;
    logic                 any_d;
    logic                 merged_q;
    logic                 pin_q;
    logic                 pin_oe_n_q;
    logic                 sirq_q;

    // write strobe aimed at one offset
    function automatic logic wr_hit(input reg_req_s r, input logic [7:0] off);
        return r.wr && (r.addr == off);
    endfunction

    // read strobe aimed at one offset
    function automatic logic rd_hit(input reg_req_s r, input logic [7:0] off);
        return r.rd && (r.addr == off);
    endfunction

    // one status byte: level bits copy the source, the rest are sticky
    // and a new event beats a clear that lands in the same cycle
    function automatic logic [7:0] sts_next(
        input logic [7:0] old,
        input logic [7:0] set,
        input logic [7:0] clr,
        input logic [7:0] lvl
    );
        logic [7:0] sticky;
        sticky = set | (old & ~clr);
        return (set & lvl) | (sticky & ~lvl);
    endfunction

    // gather the sources into the bank layout
    // only the five used peripheral levels reach the first bank
    always_comb
    begin
        set_d[0] = src.periph & STS_LEVEL[0];
        set_d[1] = {3'h0, src.kbc_pin, src.ring, src.smb, src.kbd, src.mouse};
        set_d[2] = src.gp_a;
        set_d[3] = src.gp_b;
        set_d[4] = src.gp_c;
        set_d[5] = src.gp_d;
    end

    // enable registers, reserved bits masked off at write time
    // so reads and the merge can never disagree about a reserved bit
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < NREG; i++)
            begin
                en_q[i] <= EN_RST;
            end
        end
        else if (ce)
        begin
            for (int i = 0; i < NREG; i++)
            begin
                if (wr_hit(req, EN_OFF[i]))
                begin
                    en_q[i] <= req.wdata & EN_WMASK[i];
                end
            end
        end
    end

    // status registers; the first bank has no write-clear mask at all
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < NREG; i++)
            begin
                sts_q[i] <= STS_RST[i];
            end
        end
        else if (ce)
        begin
            for (int i = 0; i < NREG; i++)
            begin
                sts_q[i] <= sts_next(sts_q[i], set_d[i],
                    wr_hit(req, STS_OFF[i]) ? (req.wdata & STS_W1C[i]) : 8'h00,
                    STS_LEVEL[i]);
            end
        end
    end

    // per-bank gating of status by enable
    always_comb
    begin
        hit_d[0] = sts_q[0] & en_q[0] & EN_GATE[0];
        hit_d[1] = sts_q[1] & en_q[1] & EN_GATE[1];
        hit_d[2] = sts_q[2] & en_q[2] & EN_GATE[2];
        hit_d[3] = sts_q[3] & en_q[3] & EN_GATE[3];
        hit_d[4] = sts_q[4] & en_q[4] & EN_GATE[4];
        hit_d[5] = sts_q[5] & en_q[5] & EN_GATE[5];
        any_d = |hit_d;
    end

    // read mux; unmapped offsets answer zero
    always_comb
    begin
        rdata_d = RD_IDLE;
        for (int i = 0; i < NREG; i++)
        begin
            if (rd_hit(req, STS_OFF[i]))
            begin
                rdata_d = sts_q[i];
            end
            if (rd_hit(req, EN_OFF[i]))
            begin
                rdata_d = en_q[i];
            end
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rdata_q <= RD_IDLE;
        end
        else if (ce)
        begin
            rdata_q <= rdata_d;
        end
    end

    // merged interrupt, registered so the output never glitches
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            merged_q <= 1'b1;
        end
        else if (ce)
        begin
            merged_q <= ~any_d;
        end
    end

    // dedicated pin; left undriven when routing is off, so a
    // board pull-up decides its level whatever the buffer type
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pin_q      <= 1'b1;
            pin_oe_n_q <= 1'b1;
        end
        else if (ce)
        begin
            pin_q      <= ~any_d;
            pin_oe_n_q <= ~en_q[SLOT_B][ROUTE_PIN_BIT];
        end
    end

    // request toward the serial interrupt framer, active high
    // a level, not a pulse: the framer picks its own slot in the stream
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sirq_q <= 1'b0;
        end
        else if (ce)
        begin
            sirq_q <= any_d & en_q[SLOT_B][ROUTE_SIRQ_BIT];
        end
    end

    assign rdata             = rdata_q;
    assign merged_mgmt_irq_n = merged_q;
    assign mgmt_irq_pin_n    = pin_q;
    assign mgmt_irq_pin_oe_n = pin_oe_n_q;
    assign serial_irq_smi    = sirq_q;

    // checks, all in the single clock domain
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_en_a_reserved: assert property (
        ce && wr_hit(req, EN_OFF[0]) |=> (en_q[0] & ~EN_WMASK[0]) == 8'h00
            && en_q[0] == ($past(req.wdata) & EN_WMASK[0]))
        else $error("first enable register stored a reserved bit");

    a_merge_low: assert property (
        ce && any_d |=> !merged_mgmt_irq_n)
        else $error("merged interrupt not asserted for enabled source");

    a_merge_high: assert property (
        ce && !any_d |=> merged_mgmt_irq_n)
        else $error("merged interrupt asserted with no enabled source");

    a_serial_route: assert property (
        ce |=> serial_irq_smi ==
            ($past(any_d) && $past(en_q[SLOT_B][ROUTE_SIRQ_BIT])))
        else $error("serial stream request does not match routing");

    a_pin_float: assert property (
        ce && !en_q[SLOT_B][ROUTE_PIN_BIT] |=> mgmt_irq_pin_oe_n)
        else $error("pin driven while routing disabled");

    a_pin_follow: assert property (
        ce && en_q[SLOT_B][ROUTE_PIN_BIT] |=> !mgmt_irq_pin_oe_n
            && mgmt_irq_pin_n == merged_mgmt_irq_n)
        else $error("pin does not carry merged interrupt");

    a_smb_clear: assert property (
        ce && wr_hit(req, STS_OFF[SLOT_B]) && req.wdata[SMB_BIT] && !src.smb
            |=> !sts_q[SLOT_B][SMB_BIT])
        else $error("sticky event status not cleared by write");

    a_smb_set_wins: assert property (
        ce && !rst && src.smb |=> sts_q[SLOT_B][SMB_BIT])
        else $error("event lost against clear");

    // an attempt begun at the release edge meets the reset branch, so skip it
    a_periph_follow: assert property (
        ce && !rst |=> sts_q[0] == ($past(src.periph) & STS_LEVEL[0]))
        else $error("peripheral status does not follow source");

    a_gpio_d_read: assert property (
        ce && rd_hit(req, EN_OFF[5]) |=> rdata == $past(en_q[5]))
        else $error("sixth enable read back wrong");

    a_read_window: assert property (
        ce && !req.rd ##1 ce |-> rdata == RD_IDLE)
        else $error("read data present without read strobe");

    // end to end: a source seen at one edge, its enable standing at the
    // next, must pull the merge low one edge later; a clear landing in
    // between cannot undo it, as the merge samples the status before it
    a_parport_merge: assert property (
        ce && !rst && src.periph[1] ##1 ce && en_q[0][1] |=> !merged_mgmt_irq_n)
        else $error("parallel port interrupt not merged");

    a_midi_merge: assert property (
        ce && !rst && src.periph[2] ##1 ce && en_q[0][2] |=> !merged_mgmt_irq_n)
        else $error("midi uart interrupt not merged");

    a_watchdog_merge: assert property (
        ce && !rst && src.periph[7] ##1 ce && en_q[0][7] |=> !merged_mgmt_irq_n)
        else $error("watchdog interrupt not merged");

    a_mouse_merge: assert property (
        ce && !rst && src.mouse ##1 ce && en_q[SLOT_B][0] |=> !merged_mgmt_irq_n)
        else $error("mouse interrupt not merged");

    a_smbus_merge: assert property (
        ce && !rst && src.smb ##1 ce && en_q[SLOT_B][SMB_BIT] |=> !merged_mgmt_irq_n)
        else $error("smbus event not merged");

    a_ring_merge: assert property (
        ce && !rst && src.ring ##1 ce && en_q[SLOT_B][3] |=> !merged_mgmt_irq_n)
        else $error("ring indicator event not merged");

    a_kbc_pin_merge: assert property (
        ce && !rst && src.kbc_pin ##1 ce && en_q[SLOT_B][4] |=> !merged_mgmt_irq_n)
        else $error("port pin event not merged");

    a_gpio_a_merge: assert property (
        ce && !rst && src.gp_a[6] ##1 ce && en_q[2][6] |=> !merged_mgmt_irq_n)
        else $error("third bank pin event not merged");

    a_gpio_b_merge: assert property (
        ce && !rst && src.gp_b[0] ##1 ce && en_q[3][0] |=> !merged_mgmt_irq_n)
        else $error("fourth bank pin event not merged");

    a_tach_merge: assert property (
        ce && !rst && src.gp_b[5] ##1 ce && en_q[3][5] |=> !merged_mgmt_irq_n)
        else $error("tachometer event not merged");

    a_gpio_c_merge: assert property (
        ce && !rst && src.gp_c[0] ##1 ce && en_q[4][0] |=> !merged_mgmt_irq_n)
        else $error("fifth bank pin event not merged");

    a_gpio_d_merge: assert property (
        ce && !rst && src.gp_d[7] ##1 ce && en_q[5][7] |=> !merged_mgmt_irq_n)
        else $error("sixth bank pin event not merged");

    a_periph_no_clear: assert property (
        ce && !rst && wr_hit(req, STS_OFF[0]) && src.periph[1] |=> sts_q[0][1])
        else $error("peripheral status cleared by a write");

    // reserved bits must never be stored, whatever software writes
    a_reserved_zero: assert property (
        (en_q[0] & ~EN_WMASK[0]) == 8'h00
            && (en_q[SLOT_B] & ~EN_WMASK[SLOT_B]) == 8'h00
            && (en_q[2] & ~EN_WMASK[2]) == 8'h00)
        else $error("reserved enable bit holds a one");

    // routing bits sit beside the gates, so a write must keep both
    a_en_b_write: assert property (
        ce && !rst && wr_hit(req, EN_OFF[SLOT_B])
            |=> en_q[SLOT_B] == ($past(req.wdata) & EN_WMASK[SLOT_B]))
        else $error("second enable register stored a reserved bit");

    // scenarios the bench is expected to reach
    c_pin_assert: cover property (
        ce && en_q[SLOT_B][ROUTE_PIN_BIT] ##1 !mgmt_irq_pin_n);

    c_serial_req: cover property (ce ##1 serial_irq_smi);

    c_clear_race: cover property (
        ce && src.smb && wr_hit(req, STS_OFF[SLOT_B]) && req.wdata[SMB_BIT]);

    c_tach_merge: cover property (ce && hit_d[3][5] ##1 !merged_mgmt_irq_n);

    c_watchdog_merge: cover property (ce && hit_d[0][7] ##1 !merged_mgmt_irq_n);

endmodule
`default_nettype wire

// ===== bench/smi_host_model.sv
// host side that takes the management interrupt
`timescale 1ns/1ps
`default_nettype none
module smi_host_model (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pin_n,
    input  wire logic oe_n,
    input  wire logic sirq,
    output logic      pin_level,
    output var int    taken
);
    // released pin is pulled up, so a float never shows a stale low
    assign pin_level = oe_n ? 1'b1 : pin_n;
    // count cycles with a request seen on either path
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            taken <= 0;
        else if (!pin_level || sirq)
            taken <= taken + 1;
    end
endmodule
`default_nettype wire

// ===== bench/smi_enable_aggregator_tb_top.sv
// bench for the management interrupt enable block
`timescale 1ns/1ps
`default_nettype none
module smi_enable_aggregator_tb_top;
    import smi_pkg::*;
    logic        clk;
    logic        rst;
    logic        ce;
    reg_req_s    req;
    smi_src_s    src;
    logic [7:0]  rdata;
    logic        irq_n;
    logic        pin_n;
    logic        oe_n;
    logic        sirq;
    logic        pin_level;
    logic        lvl;
    logic        has;
    logic [7:0]  v;
    logic [31:0] seed;
    int          taken;
    int          fails;
    int          n_compared;
    int          en_m [NREG];

    smi_enable_aggregator dut (.clk(clk), .rst(rst), .ce(ce), .req(req), .rdata(rdata),
        .src(src), .merged_mgmt_irq_n(irq_n), .mgmt_irq_pin_n(pin_n),
        .mgmt_irq_pin_oe_n(oe_n), .serial_irq_smi(sirq));
    smi_host_model host (.clk(clk), .rst(rst), .pin_n(pin_n), .oe_n(oe_n), .sirq(sirq),
        .pin_level(pin_level), .taken(taken));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // bit of the packed source struct for bank b, bit i
    function automatic int pos(input int b, input int i);
        int base [NREG] = '{37, 0, 24, 16, 8, 0};
        return (b == 1) ? 36 - i : base[b] + i;
    endfunction
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: w, rd: r};
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        op(1'b1, 1'b0, a, d);
        op(1'b0, 1'b0, a, d);
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        op(1'b0, 1'b1, a, 8'h00);
        op(1'b0, 1'b0, a, 8'h00);
        #1 chk("rdata", rdata, exp);
    endtask
    task automatic wen(input int b, input logic [7:0] d);
        en_m[b] = d & EN_WMASK[b];
        wr(EN_OFF[b], d);
    endtask
    // merge takes two edges from source; a third gives margin
    task automatic outs(input logic f);
        repeat (3) @(posedge clk);
        #1 chk("irq_n", irq_n, !f);
        chk("sirq", sirq, f & en_m[SLOT_B][ROUTE_SIRQ_BIT]);
        chk("oe_n", oe_n, !en_m[SLOT_B][ROUTE_PIN_BIT]);
        chk("pin", pin_level, !(f & en_m[SLOT_B][ROUTE_PIN_BIT]));
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // hang guard
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        final_report();
    end
    initial
    begin
        rst = 1'b1;
        ce = 1'b1;
        req = '0;
        src = '0;
        seed = 32'hd14749f1;
        fails = 0;
        n_compared = 0;
        foreach (en_m[b]) en_m[b] = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int b = 0; b < NREG; b++)
            rd(EN_OFF[b], 8'h00);
        // random patterns come back with reserved bits dropped
        for (int b = 0; b < NREG; b++)
        begin
            seed = lfsr(seed);
            wen(b, seed[7:0]);
            rd(EN_OFF[b], en_m[b][7:0]);
        end
        wr(8'h30, 8'hff);
        rd(8'h30, 8'h00);
        // a write while frozen must not land
        @(posedge clk);
        ce <= 1'b0;
        wr(EN_OFF[0], 8'h00);
        ce <= 1'b1;
        rd(EN_OFF[0], en_m[0][7:0]);
        for (int b = 0; b < NREG; b++)
            wen(b, 8'h00);
        wen(SLOT_B, 8'hc0);
        // each enable bit against its own source; levels survive a status write
        for (int b = 0; b < NREG; b++)
            for (int i = 0; i < 8; i++)
            begin
                lvl = (b == 0) || (b == 1 && i < 2);
                has = !(b == 1 && i > 4);
                v = 8'h01 << i;
                wen(b, (b == SLOT_B) ? (v | 8'hc0) : v);
                @(posedge clk);
                if (has) src[pos(b, i)] <= 1'b1;
                @(posedge clk);
                if (!lvl) src[pos(b, i)] <= 1'b0;
                outs(has && en_m[b][i]);
                wr(STS_OFF[b], 8'hff);
                outs(has && en_m[b][i] && lvl);
                @(posedge clk);
                src <= '0;
                outs(1'b0);
                wen(b, (b == SLOT_B) ? 8'hc0 : 8'h00);
            end
        // all four routing settings with one sticky event pending
        for (int r = 0; r < 4; r++)
        begin
            wen(SLOT_B, {r[1:0], 6'h04});
            @(posedge clk);
            src.smb <= 1'b1;
            @(posedge clk);
            src.smb <= 1'b0;
            outs(1'b1);
            wr(STS_OFF[SLOT_B], 8'h04);
            outs(1'b0);
        end
        // an event landing with its own clear stays set
        op(1'b1, 1'b0, STS_OFF[SLOT_B], 8'h04);
        src.smb <= 1'b1;
        op(1'b0, 1'b0, STS_OFF[SLOT_B], 8'h04);
        src.smb <= 1'b0;
        outs(1'b1);
        chk("taken", {7'h00, taken > 0}, 8'h01);
        // reset in mid-run drops enables and the pending sticky bit
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        foreach (en_m[b]) en_m[b] = 0;
        outs(1'b0);
        rd(STS_OFF[SLOT_B], 8'h00);
        rd(EN_OFF[SLOT_B], 8'h00);
        final_report();
    end
endmodule
`default_nettype wire
